// ==== dv/apc_link_partner.sv ====
// Remote link partner model that sends received pages into the block
`timescale 1ns/10ps
module apc_link_partner (
   // Clock
   input wire logic clk,
   // Page toward the block
   output logic pageValid,
   output apc_pkg::apc_page_t pageWord
);
   import apc_pkg::*;
   initial begin
      pageValid = 1'b0;
      pageWord = '0;
   end
   // One-cycle page strobe; the word is scrambled outside it
   task automatic send_page(input logic [15:0] w);
      @(posedge clk);
      #1;
      pageValid = 1'b1;
      pageWord = w;
      @(posedge clk);
      #1;
      pageValid = 1'b0;
      pageWord = ~w;
   endtask
endmodule

// ==== dv/autoneg_partner_ability_capture_tb_top.sv ====
// Self-checking bench for the partner ability capture block
`timescale 1ns/10ps
module autoneg_partner_ability_capture_tb_top;
   import apc_pkg::*;
   logic clk, resetn, ce, anEnable, overrideWrite, pageValid, rdValid;
   logic txSelValid, pageStored, partnerSel8023;
   apc_page_t pageWord;
   apc_mgmt_req_t mgmtReq;
   logic [15:0] rdData;
   logic [4:0] txSelector;
   int errCount = 0, samplesChecked = 0, cycles = 0, partner, localSel;
   logic [15:0] w;
   //************************************************************
   // Instances, clock, watchdog
   //************************************************************
   apc_capture i_dut (.clk(clk), .resetn(resetn), .ce(ce), .anEnable(anEnable),
      .overrideWrite(overrideWrite), .pageValid(pageValid), .pageWord(pageWord),
      .mgmtReq(mgmtReq), .rdData(rdData), .rdValid(rdValid), .txSelector(txSelector),
      .txSelValid(txSelValid), .pageStored(pageStored), .partnerSel8023(partnerSel8023));
   apc_link_partner i_partner (.clk(clk), .pageValid(pageValid), .pageWord(pageWord));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         errCount++;
         finalReport();
      end
   end
   task automatic finalReport();
      if (errCount == 0 && samplesChecked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
      samplesChecked++;
      if (got !== exp) begin
         errCount++;
         $display("ERROR %0t word got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic check_flag(input logic got, input logic exp);
      samplesChecked++;
      if (got !== exp) begin
         errCount++;
         $display("ERROR %0t flag got %b expected %b", $time, got, exp);
      end
   endtask
   //************************************************************
   // Bus tasks and reference model
   //************************************************************
   task automatic read_reg(input logic [4:0] a);
      logic [15:0] e;
      e = (a == ADDR_PARTNER) ? 16'(partner) : (a == ADDR_LOCAL_ADV) ? 16'(localSel) : 16'h0000;
      @(posedge clk);
      #1;
      mgmtReq = {1'b1, 1'b0, a, 16'h0000};
      @(posedge clk);
      #1;
      mgmtReq = '0;
      check_flag(rdValid, 1'b1);
      check_word(rdData, e);
   endtask
   // Reserved bits are written as their zero defaults
   task automatic write_reg(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk);
      #1;
      mgmtReq = {1'b0, 1'b1, a, d};
      @(posedge clk);
      #1;
      mgmtReq = '0;
      if (overrideWrite && a == ADDR_LOCAL_ADV) localSel = d[4:0];
      if (overrideWrite && a == ADDR_PARTNER) partner = (partner & 16'hfff0) | d[3:0];
   endtask
   task automatic check_sel();
      @(posedge clk);
      #1;
      check_flag(partnerSel8023, partner[4:0] == 5'h01);
   endtask
   task automatic check_tx();
      repeat (2) @(posedge clk);
      #1;
      check_flag(txSelValid, anEnable);
      check_word({11'h000, txSelector}, anEnable ? 16'(localSel) : 16'h0000);
   endtask
   //************************************************************
   // Scenarios
   //************************************************************
   initial begin
      void'($urandom(37));
      {ce, anEnable, overrideWrite, resetn} = 4'h8;
      mgmtReq = '0;
      partner = 0;
      localSel = 1;
      repeat (16) @(posedge clk);
      #1 resetn = 1'b1;
      repeat (3) @(posedge clk);
      read_reg(ADDR_PARTNER);
      read_reg(ADDR_LOCAL_ADV);
      // Pages are read back right after they are stored, with negotiation left disabled
      for (int i = 0; i < 12; i++) begin
         w = 16'($urandom);
         if (i < 2) w[4:0] = 5'(i + 1);
         i_partner.send_page(w);
         partner = w & 16'he1ff;
         check_flag(pageStored, 1'b1);
         check_sel();
         read_reg(ADDR_PARTNER);
         read_reg(5'(6 + i)); // Unmapped
      end
      // A read taken the cycle right after a page must see the whole new page
      for (int k = 0; k < 4; k++) begin
         w = 16'($urandom);
         partner = w & 16'he1ff;
         fork
            i_partner.send_page(w);
            begin
               @(posedge clk);
               read_reg(ADDR_PARTNER);
            end
         join
      end
      for (int ov = 0; ov < 2; ov++) begin
         overrideWrite = ov[0];
         write_reg(ADDR_LOCAL_ADV, 16'($urandom) & 16'h001f);
         write_reg(ADDR_PARTNER, 16'($urandom) & 16'h000f);
         check_sel();
         read_reg(ADDR_LOCAL_ADV);
         read_reg(ADDR_PARTNER);
         for (int e = 0; e < 2; e++) begin
            anEnable = e[0];
            check_tx();
         end
      end
      // Frozen clock enable must not take a page
      ce = 1'b0;
      i_partner.send_page(16'($urandom));
      check_flag(pageStored, 1'b0);
      ce = 1'b1;
      read_reg(ADDR_PARTNER);
      // Second reset in mid-run
      resetn = 1'b0;
      #1;
      check_flag(txSelValid, 1'b0);
      check_flag(rdValid, 1'b0);
      repeat (2) @(posedge clk);
      #1 resetn = 1'b1;
      partner = 0;
      localSel = 1;
      repeat (3) @(posedge clk);
      read_reg(ADDR_PARTNER);
      read_reg(ADDR_LOCAL_ADV);
      finalReport();
   end
endmodule

// ==== include/apc_pkg.sv ====
// Constants and carrier types for the partner ability capture block
//****************************************************************************
// Notes on behaviour
// (RULE1) Enabled negotiation sends five-bit local selector
// (RULE2) Whole partner word loads from received page
// (RULE3) Software trusts contents only after completion
// (RULE4) Next-page bit: 0 last, 1 more
// (RULE5) Acknowledge bit shows partner received our word
// (RULE6) Remote-fault bit follows received page bit
// (RULE7) Four technology bits mirror partner advertisement
// (RULE8) Four-pair 100 Mb/s bit always reads 0
// (RULE9) Three reserved technology bits always read 0
// (RULE10) Software writes defaults into reserved bits
// (RULE11) Selector reports partner message encoding code
// (RULE12) Override-write bits need override bit set
// (RULE13) All partner fields update together, atomically
//****************************************************************************
package apc_pkg;

   //*************************************************************************
   // Sizes and addresses
   //*************************************************************************
   localparam int ADDR_W = 5;
   localparam int DATA_W = 16;
   localparam int SEL_W = 5;
   localparam int TECH_W = 8;
   localparam int CW_SEL_BITS = 4;
   localparam logic [4:0] ADDR_LOCAL_ADV = 5'h04;
   localparam logic [4:0] ADDR_PARTNER = 5'h05;

   //*************************************************************************
   // Codes, masks and reset values
   //*************************************************************************
   localparam logic [4:0] SEL_IEEE_8023 = 5'h01;
   localparam logic [4:0] SEL_IEEE_8029 = 5'h02;
   localparam logic [4:0] LOCAL_SEL_RESET = 5'h01;
   localparam logic [15:0] PARTNER_RESET = 16'h0000;
   localparam logic [15:0] RDATA_RESET = 16'h0000;
   // Technology bits 3:0 are the four supported abilities
   localparam logic [7:0] TECH_SUPPORTED_MASK = 8'h0f;
   localparam int TECH_T4_POS = 4;
   localparam int RSVD_LO_POS = 5;
   localparam int RSVD_HI_POS = 7;
   localparam int READ_LATENCY = 1;

   //*************************************************************************
   // Carriers
   //*************************************************************************
   typedef struct packed {
      logic nextPage;
      logic ack;
      logic remoteFault;
      logic [7:0] techAbility;
      logic [4:0] selector;
   } apc_page_t;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [4:0] addr;
      logic [15:0] wrData;
   } apc_mgmt_req_t;

endpackage

// ==== rtl/apc_capture.sv ====
// Partner ability capture with local selector and management read port
`timescale 1ns/10ps
module apc_capture (
   // Clock, reset, enable
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   // Control from the management registers
   input wire logic anEnable,
   input wire logic overrideWrite,
   // Page from the negotiation engine
   input wire logic pageValid,
   input wire apc_pkg::apc_page_t pageWord,
   // Management register access
   input wire apc_pkg::apc_mgmt_req_t mgmtReq,
   output logic [apc_pkg::DATA_W-1:0] rdData,
   output logic rdValid,
   // Toward the link
   output logic [apc_pkg::SEL_W-1:0] txSelector,
   output logic txSelValid,
   // Status
   output logic pageStored,
   output logic partnerSel8023
);
   import apc_pkg::*;

   //*************************************************************************
   // Reset release
   //*************************************************************************
   logic rstMeta;
   logic rstnSync;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rstMeta <= 1'b0;
         rstnSync <= 1'b0;
      end else begin
         rstMeta <= 1'b1;
         rstnSync <= rstMeta;
      end
   end

   //*************************************************************************
   // Local selector
   //*************************************************************************
   logic [SEL_W-1:0] localSel;
   logic [SEL_W-1:0] next_localSel;
   logic wrLocal;
   logic wrPartner;
   logic rdPartner;

   assign wrLocal = mgmtReq.wr && (mgmtReq.addr == ADDR_LOCAL_ADV);
   assign wrPartner = mgmtReq.wr && (mgmtReq.addr == ADDR_PARTNER);
   assign rdPartner = mgmtReq.rd && (mgmtReq.addr == ADDR_PARTNER);

   always_comb begin
      next_localSel = localSel;
      // Selector is override-write; plain writes are dropped silently
      if (wrLocal && overrideWrite) begin // [RULE12]
         next_localSel = mgmtReq.wrData[SEL_W-1:0];
      end
   end

   always_ff @(posedge clk or negedge rstnSync) begin
      if (!rstnSync) begin
         localSel <= LOCAL_SEL_RESET;
      end else if (ce) begin
         localSel <= next_localSel;
      end
   end

   //*************************************************************************
   // Partner word
   //*************************************************************************
   apc_page_t partnerWord;

   apc_partner_store u_store (
      .clk(clk),
      .rstn(rstnSync),
      .ce(ce),
      .loadEn(pageValid),
      .loadPage(pageWord),
      .cwWrEn(wrPartner && overrideWrite),
      .cwWrData(mgmtReq.wrData[CW_SEL_BITS-1:0]),
      .page(partnerWord)
   );

   //*************************************************************************
   // Registered outputs
   //*************************************************************************
   logic [DATA_W-1:0] next_rdData;
   logic next_rdValid;
   logic [SEL_W-1:0] next_txSelector;
   logic next_txSelValid;
   logic next_pageStored;
   logic next_partnerSel8023;

   always_comb begin
      next_rdValid = mgmtReq.rd;
      next_rdData = RDATA_RESET;
      if (mgmtReq.rd) begin
         case (mgmtReq.addr)
            ADDR_LOCAL_ADV: begin
               next_rdData = DATA_W'(localSel);
            end
            ADDR_PARTNER: begin
               // Stored word already has the unsupported bits cleared
               next_rdData = partnerWord; // [RULE4] [RULE5] [RULE6] [RULE7] [RULE11]
            end
            default: begin
               next_rdData = RDATA_RESET;
            end
         endcase
      end
      // Nothing is sent while negotiation is off
      next_txSelValid = anEnable; // [RULE1]
      next_txSelector = anEnable ? localSel : '0; // [RULE1]
      next_pageStored = pageValid;
      // Reflects the stored word, so it lags a new page by two cycles
      next_partnerSel8023 = (partnerWord.selector == SEL_IEEE_8023); // [RULE11]
   end

   always_ff @(posedge clk or negedge rstnSync) begin
      if (!rstnSync) begin
         rdData <= RDATA_RESET;
         rdValid <= 1'b0;
         txSelector <= '0;
         txSelValid <= 1'b0;
         pageStored <= 1'b0;
         partnerSel8023 <= 1'b0;
      end else if (ce) begin
         rdData <= next_rdData;
         rdValid <= next_rdValid;
         txSelector <= next_txSelector;
         txSelValid <= next_txSelValid;
         pageStored <= next_pageStored;
         partnerSel8023 <= next_partnerSel8023;
      end
   end

   //*************************************************************************
   // Checks
   //*************************************************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstnSync);

   sequence page_in_s;
      ce && pageValid;
   endsequence

   sequence read_partner_s;
      ce && rdPartner && !pageValid;
   endsequence

   sel_sent_a: assert property ( // [RULE1]
      ce && anEnable |=> txSelValid && (txSelector == $past(localSel)))
      else $error("local selector not sent while negotiation enabled");

   sel_quiet_a: assert property ( // [RULE1]
      ce && !anEnable |=> !txSelValid && (txSelector == '0))
      else $error("selector sent while negotiation disabled");

   word_load_a: assert property ( // [RULE2]
      page_in_s |=> (partnerWord.nextPage == $past(pageWord.nextPage))
         && (partnerWord.selector == $past(pageWord.selector)))
      else $error("partner word not loaded from page");

   next_ack_a: assert property ( // [RULE4]
      page_in_s ##1 read_partner_s |=> rdValid
         && (rdData[15] == $past(pageWord.nextPage, 2))
         && (rdData[14] == $past(pageWord.ack, 2)))
      else $error("next-page or acknowledge read wrong");

   fault_follow_a: assert property ( // [RULE6]
      page_in_s |=> partnerWord.remoteFault == $past(pageWord.remoteFault))
      else $error("remote fault bit does not follow page");

   tech_mirror_a: assert property ( // [RULE7]
      page_in_s |=> partnerWord.techAbility[3:0] == $past(pageWord.techAbility[3:0]))
      else $error("technology bits do not follow page");

   t4_zero_a: assert property ( // [RULE8]
      rdValid && $past(rdPartner) |-> rdData[SEL_W + TECH_T4_POS] == 1'b0)
      else $error("four-pair ability bit read as one");

   rsvd_zero_a: assert property ( // [RULE9]
      partnerWord.techAbility[RSVD_HI_POS:RSVD_LO_POS] == 3'h0)
      else $error("reserved technology bits not zero");

   sel_report_a: assert property ( // [RULE11]
      read_partner_s ##1 ce |=> partnerSel8023 == ($past(partnerWord.selector, 2) == SEL_IEEE_8023))
      else $error("selector status does not match stored code");

   cw_block_a: assert property ( // [RULE12]
      ce && wrLocal && !overrideWrite |=> $stable(localSel))
      else $error("override-write bit changed without override");

   cw_accept_a: assert property ( // [RULE12]
      ce && wrLocal && overrideWrite |=> localSel == $past(mgmtReq.wrData[SEL_W-1:0]))
      else $error("override write not accepted");

   atomic_a: assert property ( // [RULE13]
      page_in_s ##1 read_partner_s |=> rdData == ($past(pageWord, 2)
         & {3'h7, TECH_SUPPORTED_MASK, 5'h1f}))
      else $error("read returned mixed page contents");

   hold_a: assert property ( // [RULE13]
      !ce |=> $stable(partnerWord) && $stable(localSel))
      else $error("state moved while clock enable low");

endmodule

// ==== rtl/apc_partner_store.sv ====
// Storage for the captured partner ability word
`timescale 1ns/10ps
module apc_partner_store (
   // Clock, reset, enable
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   // Received page
   input wire logic loadEn,
   input wire apc_pkg::apc_page_t loadPage,
   // Override write of selector bits
   input wire logic cwWrEn,
   input wire logic [apc_pkg::CW_SEL_BITS-1:0] cwWrData,
   // Stored word
   output apc_pkg::apc_page_t page
);
   import apc_pkg::*;

   apc_page_t next_page;

   always_comb begin
      next_page = page;
      if (loadEn) begin
         // One assignment so a read never sees half a page
         next_page = loadPage; // [RULE2] [RULE13]
         next_page.techAbility = loadPage.techAbility & TECH_SUPPORTED_MASK; // [RULE8] [RULE9]
      end else if (cwWrEn) begin
         // A received page beats a software write in the same cycle
         next_page.selector[CW_SEL_BITS-1:0] = cwWrData; // [RULE12]
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         page <= PARTNER_RESET;
      end else if (ce) begin
         page <= next_page;
      end
   end

endmodule
